// ==== shared/current_power_calc_engine_consts.svh ====
`ifndef CURRENT_POWER_CALC_ENGINE_CONSTS_SVH
`define CURRENT_POWER_CALC_ENGINE_CONSTS_SVH

// ===========================================================================
// Register pointer values
`define ADDR_MEASUREMENT_CONFIG  8'h00
`define ADDR_SHUNT_VOLTAGE       8'h01
`define ADDR_RAIL_VOLTAGE        8'h02
`define ADDR_POWER               8'h03
`define ADDR_CURRENT             8'h04
`define ADDR_SCALE_FACTOR        8'h05

// ===========================================================================
// Configuration fields and reset values
`define CFG_RESET_VALUE          16'h4127
`define CFG_SOFT_RESET_BIT       15
`define CFG_AVG_LSB              9
`define CFG_RAIL_CT_LSB          6
`define CFG_SHUNT_CT_LSB         3
`define CFG_MODE_LSB             0
`define CFG_WRITABLE_MASK        16'h0fff
`define CFG_FIXED_BITS           16'h4000
`define SCALE_FACTOR_RESET       16'h0000

// ===========================================================================
// Arithmetic constants
`define CURRENT_DIV_SHIFT        11
`define CURRENT_ROUND_ADD        33'h0_0000_07ff
`define POWER_DIVISOR            16'd20000
`define POWER_STEP_RATIO         25
`define RAIL_STEP_UV             1250
`define SHUNT_STEP_NV            2500
`define DIV_ITERATIONS           6'd32

`endif

// ==== shared/current_power_calc_engine_pkg.sv ====
package current_power_calc_engine_pkg;

   typedef enum logic {
      calc_idle,
      calc_dividing
   } calc_state_t;

   typedef logic signed [26:0] accum_t;
   typedef logic [15:0]        word_t;

endpackage

// ==== shared/divider_if.sv ====
`timescale 1ns/100ps

interface divider_if;
   logic        start;
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic        done;
   logic [31:0] quotient;

   modport requester (
      output start,
      output dividend,
      output divisor,
      input  done,
      input  quotient
   );

   modport solver (
      input  start,
      input  dividend,
      input  divisor,
      output done,
      output quotient
   );
endinterface

// ==== testbench/calc_engine_monitor.sv ====
`timescale 1ns/100ps

// =============================================================
// Port-level checks of the calculation engine.
module calc_engine_monitor (
   // Clock and reset
   input wire logic        clock,
   input wire logic        srst,
   // Register port
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Samples and settings
   input wire logic        rail_valid,
   input wire logic [2:0]  avg_sel,
   input wire logic [2:0]  rail_ct_sel,
   input wire logic [2:0]  shunt_ct_sel,
   input wire logic [2:0]  mode_sel,
   input wire logic        average_done
);
   logic cal_seen;
   logic next_cal_seen;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // A soft reset forgets the scale factor just as the reset pin does.
   always_comb begin
      next_cal_seen = cal_seen;
      if (reg_wr && reg_addr == 8'h05)
         next_cal_seen = 1'b1;
      if (reg_wr && reg_addr == 8'h00 && reg_wdata[15])
         next_cal_seen = 1'b0;
   end

   always_ff @(posedge clock) begin
      if (srst)
         cal_seen <= 1'b0;
      else
         cal_seen <= next_cal_seen;
   end

   property p_reset_sel;
      $fell(srst) |-> {avg_sel, rail_ct_sel, shunt_ct_sel, mode_sel} == 12'h127;
   endproperty
   a_reset_sel: assert property (p_reset_sel) else $error("selects not at reset value");

   property p_cfg_write;
      reg_wr && reg_addr == 8'h00 && !reg_wdata[15]
         |=> {avg_sel, rail_ct_sel, shunt_ct_sel, mode_sel} == $past(reg_wdata[11:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("selects not loaded");

   property p_soft_reset;
      reg_wr && reg_addr == 8'h00 && reg_wdata[15] |-> ##2 mode_sel == 3'h7 && avg_sel == 3'h0;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not taken");

   property p_rail_msb;
      reg_addr == 8'h02 |=> !reg_rdata[15];
   endproperty
   a_rail_msb: assert property (p_rail_msb) else $error("rail top bit set");

   property p_unmapped;
      reg_addr > 8'h05 |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_uncal_zero;
      !cal_seen && (reg_addr == 8'h03 || reg_addr == 8'h04) |=> reg_rdata == 16'h0000;
   endproperty
   a_uncal_zero: assert property (p_uncal_zero) else $error("result without scale");

   property p_done_time;
      rail_valid && avg_sel == 3'h0 |-> ##[34:35] average_done;
   endproperty
   a_done_time: assert property (p_done_time) else $error("average not loaded in time");

   property p_done_quiet;
      rail_valid |-> ##10 !average_done [*8];
   endproperty
   a_done_quiet: assert property (p_done_quiet) else $error("early average");
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps

// =============================================================
// Self-checking bench for the calculation engine.
module tb
   import current_power_calc_engine_pkg::*;
;
   logic       clock = 1'b0;
   logic       srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   word_t      reg_wdata = 16'h0000;
   word_t      reg_rdata;
   logic       shunt_valid = 1'b0;
   word_t      shunt_code = 16'h0000;
   logic       rail_valid = 1'b0;
   word_t      rail_code = 16'h0000;
   logic [2:0] avg_sel;
   logic [2:0] rail_ct_sel;
   logic [2:0] shunt_ct_sel;
   logic [2:0] mode_sel;
   logic       average_done;
   logic       got_done;
   int         mismatches = 0;
   int         n_compared = 0;

   always #10 clock = ~clock;

   current_power_calc_engine current_power_calc_engine_inst (.clock(clock), .srst(srst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .shunt_valid(shunt_valid), .shunt_code(shunt_code), .rail_valid(rail_valid),
      .rail_code(rail_code), .avg_sel(avg_sel), .rail_ct_sel(rail_ct_sel),
      .shunt_ct_sel(shunt_ct_sel), .mode_sel(mode_sel), .average_done(average_done));

   task automatic check(input word_t seen, input word_t exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic write_reg(input logic [7:0] a, input word_t d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
   endtask

   task automatic expect_reg(input logic [7:0] a, input word_t exp, input string what);
      @(negedge clock);
      reg_addr = a;
      repeat (2) @(negedge clock);
      check(reg_rdata, exp, what);
   endtask

   // Rail pulses end up more than 40 cycles apart, so none is dropped.
   task automatic measure(input word_t s, input word_t r);
      @(negedge clock);
      shunt_code = s;
      shunt_valid = 1'b1;
      @(negedge clock);
      shunt_valid = 1'b0;
      repeat (3) @(negedge clock);
      rail_code = r;
      rail_valid = 1'b1;
      @(negedge clock);
      rail_valid = 1'b0;
      got_done = 1'b0;
      repeat (40) begin
         @(negedge clock);
         if (average_done === 1'b1)
            got_done = 1'b1;
      end
   endtask

   task automatic test_reset_values;
      expect_reg(8'h00, 16'h4127, "config");
      check({4'h0, avg_sel, rail_ct_sel, shunt_ct_sel, mode_sel}, 16'h0127, "selects");
      expect_reg(8'h05, 16'h0000, "scale");
      expect_reg(8'h06, 16'h0000, "unmapped");
   endtask

   task automatic test_uncalibrated;
      measure(16'h1f40, 16'h2570);
      check({15'h0, got_done}, 16'h0001, "done");
      expect_reg(8'h01, 16'h1f40, "shunt");
      expect_reg(8'h02, 16'h2570, "rail");
      expect_reg(8'h04, 16'h0000, "current");
      expect_reg(8'h03, 16'h0000, "power");
   endtask

   task automatic test_calibrated;
      // One milliamp per step, which covers 15 A, across a two milliohm shunt gives a scale of 2560.
      write_reg(8'h05, 16'h0a00);
      expect_reg(8'h05, 16'h0a00, "scale");
      measure(16'h1f40, 16'h2570);
      expect_reg(8'h04, 16'h2710, "current");
      expect_reg(8'h03, 16'h12b8, "power");
      measure(16'he0c0, 16'ha570);
      expect_reg(8'h02, 16'h2570, "rail");
      expect_reg(8'h04, 16'hd8f0, "negative current");
      expect_reg(8'h03, 16'h12b8, "power");
      write_reg(8'h05, 16'h03e8);
      measure(16'hfffd, 16'h7530);
      expect_reg(8'h04, 16'hffff, "truncated current");
      expect_reg(8'h03, 16'h0001, "power");
   endtask

   task automatic test_read_only;
      write_reg(8'h04, 16'h1234);
      expect_reg(8'h04, 16'hffff, "current");
      write_reg(8'h06, 16'h1234);
      expect_reg(8'h06, 16'h0000, "unmapped");
   endtask

   // An ammeter reads 10100 where the engine showed 10000, so the scale becomes 2560 * 10100 / 10000, truncated.
   task automatic test_field_correction;
      write_reg(8'h05, 16'h0a19);
      expect_reg(8'h05, 16'h0a19, "corrected scale");
      measure(16'h1f40, 16'h2570);
      expect_reg(8'h04, 16'h2771, "corrected current");
      expect_reg(8'h03, 16'h12e6, "corrected power");
   endtask

   // Powers 5, 20, 45 and 80 average to 37 after truncation.
   task automatic test_averaging;
      write_reg(8'h05, 16'h0800);
      write_reg(8'h00, 16'h0327);
      expect_reg(8'h00, 16'h4327, "config");
      for (int i = 1; i <= 4; i++) begin
         measure(word_t'(100 * i), word_t'(1000 * i));
         check({15'h0, got_done}, word_t'(i == 4), "done");
      end
      expect_reg(8'h01, 16'h00fa, "shunt");
      expect_reg(8'h02, 16'h09c4, "rail");
      expect_reg(8'h04, 16'h00fa, "current");
      expect_reg(8'h03, 16'h0025, "power");
   endtask

   task automatic test_soft_reset;
      write_reg(8'h00, 16'h8000);
      repeat (2) @(negedge clock);
      expect_reg(8'h00, 16'h4127, "config");
      expect_reg(8'h05, 16'h0000, "scale");
      measure(16'h1f40, 16'h2570);
      expect_reg(8'h04, 16'h0000, "current");
   endtask

   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (6) @(negedge clock);
      srst = 1'b0;
      test_reset_values;
      test_uncalibrated;
      test_calibrated;
      test_read_only;
      test_field_correction;
      test_averaging;
      test_soft_reset;
      complete_run;
   end

   // The sequence needs about 570 cycles; some thirty-five times that means a hang.
   initial begin
      #400000;
      mismatches++;
      complete_run;
   end
endmodule

bind current_power_calc_engine calc_engine_monitor calc_engine_monitor_inst (.clock(clock), .srst(srst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .rail_valid(rail_valid), .avg_sel(avg_sel), .rail_ct_sel(rail_ct_sel),
   .shunt_ct_sel(shunt_ct_sel), .mode_sel(mode_sel), .average_done(average_done));

// ==== verilog/current_power_calc_engine.sv ====
// Summary of operation
// - Current equals shunt code times scale over 2048.
// - Power equals current magnitude times rail code over 20000.
// - Power step is 25 current steps.
// - Unwritten scale factor keeps current, power zero.
// - Written scale factor refreshes results at the end of every average.
// - Rail code step is 1.25 mV.
// - Rail result top bit always reads zero.
// - Shunt code step is 2.5 uV.
// - Register pointers 00h through 05h as mapped.
// - Configuration holds averaging and two conversion times.
// - Current computed right after each shunt conversion.
// - Power computed after rail conversion from last current.
// - Averages of all four loaded into output registers.
`timescale 1ns/100ps
`include "current_power_calc_engine_consts.svh"

module current_power_calc_engine
   import current_power_calc_engine_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // Register port from the serial slave
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   // Converter samples
   input  wire logic        shunt_valid,
   input  wire logic [15:0] shunt_code,
   input  wire logic        rail_valid,
   input  wire logic [15:0] rail_code,
   // Converter settings
   output logic      [2:0]  avg_sel,
   output logic      [2:0]  rail_ct_sel,
   output logic      [2:0]  shunt_ct_sel,
   output logic      [2:0]  mode_sel,
   output logic             average_done
);

   divider_if div ();

   power_divider u_power_divider (
      .clock (clock),
      .srst  (srst),
      .div   (div)
   );

   // ========================================================================
   // State
   word_t       config_reg,  next_config_reg;
   word_t       scale,       next_scale;
   logic        cal_written, next_cal_written;
   word_t       shunt_out,   next_shunt_out;
   word_t       rail_out,    next_rail_out;
   word_t       current_out, next_current_out;
   word_t       power_out,   next_power_out;
   word_t       last_current, next_last_current;
   word_t       rail_hold,   next_rail_hold;
   accum_t      acc_shunt,   next_acc_shunt;
   accum_t      acc_current, next_acc_current;
   accum_t      acc_rail,    next_acc_rail;
   accum_t      acc_power,   next_acc_power;
   logic [10:0] samples,     next_samples;
   calc_state_t state,       next_state;
   word_t       next_rdata;
   logic        next_average_done;

   logic [3:0]         avg_shift;
   logic [10:0]        avg_target;
   logic signed [32:0] shunt_product;
   logic signed [32:0] shunt_rounded;
   word_t              current_calc;
   word_t              current_mag;
   word_t              power_calc;
   logic               cfg_write;
   logic               soft_reset;

   // Averaging counts 1, 4, 16, 64, 128, 256, 512 and 1024 are all powers of two,
   // so the average is a plain arithmetic shift of the accumulator.
   always_comb begin
      case (config_reg[`CFG_AVG_LSB +: 3])
         3'd0:    avg_shift = 4'd0;
         3'd1:    avg_shift = 4'd2;
         3'd2:    avg_shift = 4'd4;
         3'd3:    avg_shift = 4'd6;
         3'd4:    avg_shift = 4'd7;
         3'd5:    avg_shift = 4'd8;
         3'd6:    avg_shift = 4'd9;
         default: avg_shift = 4'd10;
      endcase
   end
   assign avg_target = 11'd1 << avg_shift;

   // ========================================================================
   // Current arithmetic
   assign shunt_product = $signed(shunt_code) * $signed({1'b0, scale});
   // Adding 2047 before the shift makes negative quotients truncate toward zero.
   assign shunt_rounded = shunt_product[32] ? (shunt_product + $signed(`CURRENT_ROUND_ADD)) : shunt_product;
   assign current_calc  = cal_written ? shunt_rounded[`CURRENT_DIV_SHIFT +: 16] : 16'h0000;
   // Power is a magnitude; its step is 25 current steps because the 20000
   // divisor times the 1.25 mV rail step gives 25.
   assign current_mag   = last_current[15] ? (16'h0000 - last_current) : last_current;
   assign power_calc    = cal_written ? div.quotient[15:0] : 16'h0000;

   assign div.start    = (state == calc_idle) && rail_valid;
   assign div.dividend = {16'h0000, current_mag} * {17'h0_0000, rail_code[14:0]};
   assign div.divisor  = `POWER_DIVISOR;

   assign cfg_write  = reg_wr && (reg_addr == `ADDR_MEASUREMENT_CONFIG);
   assign soft_reset = cfg_write && reg_wdata[`CFG_SOFT_RESET_BIT];

   // ========================================================================
   // Next-state logic
   always_comb begin
      next_config_reg   = config_reg;
      next_scale        = scale;
      next_cal_written  = cal_written;
      next_shunt_out    = shunt_out;
      next_rail_out     = rail_out;
      next_current_out  = current_out;
      next_power_out    = power_out;
      next_last_current = last_current;
      next_rail_hold    = rail_hold;
      next_acc_shunt    = acc_shunt;
      next_acc_current  = acc_current;
      next_acc_rail     = acc_rail;
      next_acc_power    = acc_power;
      next_samples      = samples;
      next_state        = state;
      next_average_done = 1'b0;

      if (shunt_valid) begin
         next_last_current = current_calc;
         next_acc_shunt    = acc_shunt + accum_t'($signed(shunt_code));
         next_acc_current  = acc_current + accum_t'($signed(current_calc));
      end

      case (state)
         calc_idle: begin
            if (rail_valid) begin
               next_rail_hold = {1'b0, rail_code[14:0]};
               next_state     = calc_dividing;
            end
         end
         calc_dividing: begin
            if (div.done) begin
               next_state     = calc_idle;
               next_acc_rail  = acc_rail + accum_t'(rail_hold);
               next_acc_power = acc_power + accum_t'(power_calc);
               if (samples + 11'd1 >= avg_target) begin
                  next_shunt_out    = 16'(next_acc_shunt >>> avg_shift);
                  next_current_out  = 16'(next_acc_current >>> avg_shift);
                  next_rail_out     = 16'(next_acc_rail >>> avg_shift) & 16'h7fff;
                  next_power_out    = 16'(next_acc_power >>> avg_shift);
                  next_acc_shunt    = '0;
                  next_acc_current  = '0;
                  next_acc_rail     = '0;
                  next_acc_power    = '0;
                  next_samples      = 11'd0;
                  next_average_done = 1'b1;
               end else begin
                  next_samples = samples + 11'd1;
               end
            end
         end
         default: next_state = calc_idle;
      endcase

      // A configuration write restarts averaging; without bit 15, a division ending after the write adds its rail and power sample to the new average.
      if (cfg_write) begin
         next_config_reg  = (reg_wdata & `CFG_WRITABLE_MASK) | `CFG_FIXED_BITS;
         next_acc_shunt   = '0;
         next_acc_current = '0;
         next_acc_rail    = '0;
         next_acc_power   = '0;
         next_samples     = 11'd0;
      end
      if (reg_wr && (reg_addr == `ADDR_SCALE_FACTOR)) begin
         next_scale       = reg_wdata;
         next_cal_written = 1'b1;
      end

      if (reg_addr == `ADDR_MEASUREMENT_CONFIG) begin
         next_rdata = config_reg;
      end else if (reg_addr == `ADDR_SHUNT_VOLTAGE) begin
         next_rdata = shunt_out;
      end else if (reg_addr == `ADDR_RAIL_VOLTAGE) begin
         next_rdata = rail_out;
      end else if (reg_addr == `ADDR_POWER) begin
         next_rdata = power_out;
      end else if (reg_addr == `ADDR_CURRENT) begin
         next_rdata = current_out;
      end else if (reg_addr == `ADDR_SCALE_FACTOR) begin
         next_rdata = scale;
      end else begin
         next_rdata = 16'h0000;
      end
   end

   // ========================================================================
   // Registers
   always_ff @(posedge clock) begin
      if (srst || soft_reset) begin
         config_reg   <= `CFG_RESET_VALUE;
         scale        <= `SCALE_FACTOR_RESET;
         cal_written  <= 1'b0;
         shunt_out    <= 16'h0000;
         rail_out     <= 16'h0000;
         current_out  <= 16'h0000;
         power_out    <= 16'h0000;
         last_current <= 16'h0000;
         rail_hold    <= 16'h0000;
         acc_shunt    <= '0;
         acc_current  <= '0;
         acc_rail     <= '0;
         acc_power    <= '0;
         samples      <= 11'h000;
         state        <= calc_idle;
         reg_rdata    <= 16'h0000;
         average_done <= 1'b0;
      end else begin
         config_reg   <= next_config_reg;
         scale        <= next_scale;
         cal_written  <= next_cal_written;
         shunt_out    <= next_shunt_out;
         rail_out     <= next_rail_out;
         current_out  <= next_current_out;
         power_out    <= next_power_out;
         last_current <= next_last_current;
         rail_hold    <= next_rail_hold;
         acc_shunt    <= next_acc_shunt;
         acc_current  <= next_acc_current;
         acc_rail     <= next_acc_rail;
         acc_power    <= next_acc_power;
         samples      <= next_samples;
         state        <= next_state;
         reg_rdata    <= next_rdata;
         average_done <= next_average_done;
      end
   end

   assign avg_sel      = config_reg[`CFG_AVG_LSB +: 3];
   assign rail_ct_sel  = config_reg[`CFG_RAIL_CT_LSB +: 3];
   assign shunt_ct_sel = config_reg[`CFG_SHUNT_CT_LSB +: 3];
   assign mode_sel     = config_reg[`CFG_MODE_LSB +: 3];

endmodule

// ==== verilog/power_divider.sv ====
`timescale 1ns/100ps
`include "current_power_calc_engine_consts.svh"

// Unsigned shift-subtract divider, one quotient bit per clock.
module power_divider
   import current_power_calc_engine_pkg::*;
(
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  srst,
   // Request and answer
   divider_if.solver  div
);

   logic [31:0] quot;
   logic [31:0] next_quot;
   logic [16:0] rem;
   logic [16:0] next_rem;
   logic [15:0] dsor;
   logic [15:0] next_dsor;
   logic [5:0]  count;
   logic [5:0]  next_count;
   logic        busy;
   logic        next_busy;
   logic        done;
   logic        next_done;

   // ========================================================================
   // Iteration
   always_comb begin
      logic [16:0] trial;
      trial      = 17'd0;
      next_quot  = quot;
      next_rem   = rem;
      next_dsor  = dsor;
      next_count = count;
      next_busy  = busy;
      next_done  = 1'b0;
      if (!busy && div.start) begin
         next_quot  = div.dividend;
         next_rem   = 17'd0;
         next_dsor  = div.divisor;
         next_count = `DIV_ITERATIONS;
         next_busy  = 1'b1;
      end else if (busy) begin
         trial = {rem[15:0], quot[31]};
         if (trial >= {1'b0, dsor}) begin
            next_rem  = trial - {1'b0, dsor};
            next_quot = {quot[30:0], 1'b1};
         end else begin
            next_rem  = trial;
            next_quot = {quot[30:0], 1'b0};
         end
         next_count = count - 6'd1;
         if (count == 6'd1) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         quot  <= 32'h0000_0000;
         rem   <= 17'h0_0000;
         dsor  <= 16'h0000;
         count <= 6'h00;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         quot  <= next_quot;
         rem   <= next_rem;
         dsor  <= next_dsor;
         count <= next_count;
         busy  <= next_busy;
         done  <= next_done;
      end
   end

   assign div.done     = done;
   assign div.quotient = quot;

endmodule
